// [src/clr_consts.vh]
// Constants for the channel loss recovery controller.
`ifndef CLR_CONSTS_VH
`define CLR_CONSTS_VH
`define CLR_NCH 8
`define CLR_IDW 3
`define CLR_REG_CTRL 4'h0
`define CLR_REG_STATUS 4'h1
`define CLR_REG_IRQ_STAT 4'h2
`define CLR_REG_IRQ_CLR 4'h3
`define CLR_REG_IRQ_EN 4'h4
`define CLR_REG_FA_LIMIT 4'h5
`define CLR_REG_ERR_LIMIT 4'h6
`define CLR_REG_RATE 4'h7
`define CLR_REG_CHANS 4'h8
`define CLR_CTRL_RECOVER 0
`define CLR_CTRL_RESTORE 1
`define CLR_CTRL_ACTIVE 2
`define CLR_EV_LOST 0
`define CLR_EV_DONE 1
`define CLR_EV_DROP 2
`define CLR_EV_PEER 3
`define CLR_NEV 4
`define CLR_CTRL_RST 3'h1
`define CLR_FA_LIMIT_RST 16'h0FA0
`define CLR_ERR_LIMIT_RST 8'h10
`define CLR_RATE_RST 8'h00
`define CLR_ST_IDLE 3'h0
`define CLR_ST_TEAR 3'h1
`define CLR_ST_IND 3'h2
`define CLR_ST_RESEQ 3'h3
`define CLR_ST_REEQ 3'h4
`endif

// [src/clr_fa_timer.v]
// Frame alignment loss timer for one channel.
`timescale 1ns/1ns
`include "clr_consts.vh"
module clr_fa_timer (
   input wire clock,
   input wire arst_n,
   input wire alignLost,
   input wire [15:0] limit,
   output reg expire_ff,
   output reg restart_ff,
   output reg alarmOk_ff
);
   reg [15:0] cnt_ff;
   reg lostDly_ff;
   reg expired_ff;

   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cnt_ff <= 16'h0000;
         lostDly_ff <= 1'b0;
         expired_ff <= 1'b0;
         expire_ff <= 1'b0;
         restart_ff <= 1'b0;
         alarmOk_ff <= 1'b1;
      end else begin
         lostDly_ff <= alignLost;
         restart_ff <= alignLost & ~lostDly_ff; // [RQ13]
         alarmOk_ff <= ~alignLost; // [RQ13]
         expire_ff <= 1'b0;
         if (!alignLost) begin
            cnt_ff <= 16'h0000;
            expired_ff <= 1'b0;
         end else if (!expired_ff) begin
            if (cnt_ff >= limit) begin
               expire_ff <= 1'b1; // [RQ1]
               expired_ff <= 1'b1;
            end else begin
               cnt_ff <= cnt_ff + 16'h0001;
            end
         end
      end
   end
endmodule

// [src/clr_top.v]
// Channel loss recovery controller with Avalon-MM register slave.
// Operation
// (RQ1) Alignment loss timer expiry on a channel drops it and starts recovery.
// (RQ2) Unnegotiated network disconnect of master: finish teardown, then recover.
// (RQ3) Excessive CRC or far end errors on master drop it and recover.
// (RQ4) First step: if equalization lost, send indicator 0 on remaining channels.
// (RQ5) Reassign channel identifiers keeping the survivors' relative order.
// (RQ6) Re-equalize delays after resequencing, before aligned data resumes.
// (RQ7) Reported rate and sub-rate multipliers describe the new call state.
// (RQ8) Step rate multiplier down one and force sub-rate multiplier to zero.
// (RQ9) May request bandwidth restoration through add-channel right away.
// (RQ10) Without recovery enabled, a channel loss drops the whole call.
// (RQ11) Local equalization loss in active call: indicator 0, then re-equalize.
// (RQ12) Indicator 0 received on all channels flags peer equalization loss.
// (RQ13) Alignment loss restarts sync search and sends alarm bit 0 meanwhile.
// (RQ14) Indicator update, resequencing, re-equalization run strictly in turn.
//
// Chosen here: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ns
`include "clr_consts.vh"
module clr_top (
   input wire clock,
   input wire arst_n,
   input wire [3:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   output reg [31:0] avs_readdata,
   output reg avs_waitrequest,
   input wire [`CLR_NCH-1:0] alignLost,
   input wire [`CLR_NCH-1:0] netDisc,
   input wire discNegotiated,
   input wire masterCrcErr,
   input wire masterFarEndErr,
   input wire eqLostDetect,
   input wire eqDone,
   input wire [`CLR_NCH-1:0] rxEqOk,
   output reg [`CLR_NCH-1:0] chanDrop_ff,
   output reg [`CLR_NCH-1:0] txEqOk_ff,
   output wire [`CLR_NCH-1:0] txAlarmOk,
   output wire [`CLR_NCH-1:0] syncRestart,
   output reg [`CLR_NCH*`CLR_IDW-1:0] chanIds_ff,
   output reg [7:0] rateMult_ff,
   output reg [7:0] subRateMult_ff,
   output reg reEqStart_ff,
   output reg callDrop_ff,
   output reg addChanReq_ff,
   output reg peerEqLost_ff,
   output reg recovering_ff,
   output reg irq_ff
);
   localparam NCH = `CLR_NCH;
   localparam IDW = `CLR_IDW;

   reg [2:0] ctrl_ff;
   reg [15:0] faLimit_ff;
   reg [7:0] errLimit_ff;
   reg [7:0] errCnt_ff;
   reg [NCH-1:0] active_ff;
   reg [NCH-1:0] pendLost_ff;
   reg [NCH-1:0] lostSel_ff;
   reg [2:0] state_ff;
   reg eqLostFlag_ff;
   reg [`CLR_NEV-1:0] irqStat_ff;
   reg [`CLR_NEV-1:0] irqEn_ff;
   reg [31:0] rdMux;
   reg [NCH-1:0] masterMask;
   reg [NCH-1:0] newLost;
   reg [`CLR_NEV-1:0] ev;
   reg peerNow;
   reg found;
   integer k;
   wire [NCH-1:0] faExpire;
   wire [NCH*IDW-1:0] seqIds;
   wire acc = (avs_read | avs_write) & ~avs_waitrequest;
   wire wrAcc = avs_write & ~avs_waitrequest;
   wire errHit = (masterCrcErr | masterFarEndErr) &&
                 (errCnt_ff + 8'h01 >= errLimit_ff);
   wire callActive = ctrl_ff[`CLR_CTRL_ACTIVE];

   // The relative order of survivors is kept by counting active peers below.
   genvar g;
   generate
      for (g = 0; g < NCH; g = g + 1) begin : gch
         // The timer sees the raw pin, so a dropped channel keeps its alarm.
         // Limitation: a channel enabled while its timer is spent waits for
         // alignment to return before it can expire again.
         clr_fa_timer u_fa (
            .clock(clock),
            .arst_n(arst_n),
            .alignLost(alignLost[g]),
            .limit(faLimit_ff),
            .expire_ff(faExpire[g]),
            .restart_ff(syncRestart[g]),
            .alarmOk_ff(txAlarmOk[g])
         );
         if (g == 0) begin : gz
            assign seqIds[IDW-1:0] = {IDW{1'b0}};
         end else begin : gn
            assign seqIds[g*IDW +: IDW] = seqIds[(g-1)*IDW +: IDW] +
               {{(IDW-1){1'b0}}, active_ff[g-1]}; // [RQ5]
         end
      end
   endgenerate

   always @* begin
      masterMask = {NCH{1'b0}};
      found = 1'b0;
      for (k = 0; k < NCH; k = k + 1) begin
         if (active_ff[k] && !found) begin
            masterMask[k] = 1'b1;
            found = 1'b1;
         end
      end
      newLost = faExpire & active_ff; // [RQ1]
      if (netDisc != {NCH{1'b0}} && !discNegotiated) begin
         newLost = newLost | (netDisc & masterMask); // [RQ2]
      end
      if (errHit) begin
         newLost = newLost | masterMask; // [RQ3]
      end
      peerNow = callActive && (active_ff != {NCH{1'b0}}) &&
                ((rxEqOk & active_ff) == {NCH{1'b0}}); // [RQ12]
      ev = {`CLR_NEV{1'b0}};
      ev[`CLR_EV_LOST] = state_ff == `CLR_ST_TEAR;
      ev[`CLR_EV_DONE] = (state_ff == `CLR_ST_REEQ) && eqDone;
      ev[`CLR_EV_DROP] = callDrop_ff;
      ev[`CLR_EV_PEER] = peerNow & ~peerEqLost_ff;
   end

   always @* begin
      rdMux = 32'h0000_0000;
      case (avs_address)
         `CLR_REG_CTRL: rdMux[2:0] = ctrl_ff;
         `CLR_REG_STATUS: rdMux = {8'h00, subRateMult_ff, rateMult_ff,
            2'b00, eqLostFlag_ff, peerEqLost_ff, recovering_ff, state_ff};
         `CLR_REG_IRQ_STAT: rdMux[`CLR_NEV-1:0] = irqStat_ff;
         `CLR_REG_IRQ_EN: rdMux[`CLR_NEV-1:0] = irqEn_ff;
         `CLR_REG_FA_LIMIT: rdMux[15:0] = faLimit_ff;
         `CLR_REG_ERR_LIMIT: rdMux = {16'h0000, errCnt_ff, errLimit_ff};
         `CLR_REG_RATE: rdMux[15:0] = {subRateMult_ff, rateMult_ff}; // [RQ7]
         `CLR_REG_CHANS: rdMux = {chanIds_ff, active_ff};
         default: rdMux = 32'h0000_0000;
      endcase
   end

   // Every access takes exactly one wait cycle, so read data is registered.
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
      end else if (acc) begin
         avs_waitrequest <= 1'b1;
      end else if (avs_read | avs_write) begin
         avs_waitrequest <= 1'b0;
         avs_readdata <= avs_read ? rdMux : 32'h0000_0000;
      end
   end

   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_ff <= `CLR_CTRL_RST;
         faLimit_ff <= `CLR_FA_LIMIT_RST;
         errLimit_ff <= `CLR_ERR_LIMIT_RST;
         irqEn_ff <= {`CLR_NEV{1'b0}};
         irqStat_ff <= {`CLR_NEV{1'b0}};
         irq_ff <= 1'b0;
      end else begin
         if (wrAcc && avs_address == `CLR_REG_CTRL) begin
            ctrl_ff <= avs_writedata[2:0];
         end else if (callDrop_ff) begin
            ctrl_ff[`CLR_CTRL_ACTIVE] <= 1'b0;
         end
         if (wrAcc && avs_address == `CLR_REG_FA_LIMIT) begin
            faLimit_ff <= avs_writedata[15:0];
         end
         if (wrAcc && avs_address == `CLR_REG_ERR_LIMIT) begin
            errLimit_ff <= avs_writedata[7:0];
         end
         if (wrAcc && avs_address == `CLR_REG_IRQ_EN) begin
            irqEn_ff <= avs_writedata[`CLR_NEV-1:0];
         end
         // A new event wins over a clear written in the same cycle.
         if (wrAcc && avs_address == `CLR_REG_IRQ_CLR) begin
            irqStat_ff <= (irqStat_ff & ~avs_writedata[`CLR_NEV-1:0]) | ev;
         end else begin
            irqStat_ff <= irqStat_ff | ev;
         end
         irq_ff <= |(irqStat_ff & irqEn_ff);
      end
   end

   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_ff <= `CLR_ST_IDLE;
         active_ff <= {NCH{1'b0}};
         pendLost_ff <= {NCH{1'b0}};
         lostSel_ff <= {NCH{1'b0}};
         chanDrop_ff <= {NCH{1'b0}};
         txEqOk_ff <= {NCH{1'b0}};
         chanIds_ff <= {(NCH*IDW){1'b0}};
         rateMult_ff <= `CLR_RATE_RST;
         subRateMult_ff <= `CLR_RATE_RST;
         errCnt_ff <= 8'h00;
         eqLostFlag_ff <= 1'b0;
         reEqStart_ff <= 1'b0;
         callDrop_ff <= 1'b0;
         addChanReq_ff <= 1'b0;
         peerEqLost_ff <= 1'b0;
         recovering_ff <= 1'b0;
      end else begin
         chanDrop_ff <= {NCH{1'b0}};
         reEqStart_ff <= 1'b0;
         callDrop_ff <= 1'b0;
         addChanReq_ff <= 1'b0;
         peerEqLost_ff <= peerNow; // [RQ12]
         recovering_ff <= state_ff != `CLR_ST_IDLE;
         if (eqLostDetect && callActive) begin
            eqLostFlag_ff <= 1'b1;
         end
         if (wrAcc && avs_address == `CLR_REG_ERR_LIMIT) begin
            errCnt_ff <= 8'h00;
         end else if (errHit) begin
            errCnt_ff <= 8'h00;
         end else if (masterCrcErr | masterFarEndErr) begin
            errCnt_ff <= errCnt_ff + 8'h01;
         end
         if (state_ff == `CLR_ST_IDLE && wrAcc &&
             avs_address == `CLR_REG_RATE) begin
            rateMult_ff <= avs_writedata[7:0];
            subRateMult_ff <= avs_writedata[15:8];
         end
         pendLost_ff <= pendLost_ff | newLost;
         case (state_ff)
            `CLR_ST_IDLE: begin
               if (wrAcc && avs_address == `CLR_REG_CHANS) begin
                  active_ff <= avs_writedata[NCH-1:0];
                  txEqOk_ff <= avs_writedata[NCH-1:0];
                  pendLost_ff <= {NCH{1'b0}};
                  state_ff <= `CLR_ST_RESEQ;
               end else if (callActive &&
                            (pendLost_ff | newLost) != {NCH{1'b0}}) begin
                  lostSel_ff <= pendLost_ff | newLost;
                  pendLost_ff <= {NCH{1'b0}};
                  state_ff <= `CLR_ST_TEAR;
               end else if (callActive && eqLostDetect) begin
                  txEqOk_ff <= {NCH{1'b0}}; // [RQ11]
                  reEqStart_ff <= 1'b1; // [RQ11]
                  state_ff <= `CLR_ST_REEQ;
               end
            end
            `CLR_ST_TEAR: begin
               // Teardown of the lost channels completes before recovery.
               chanDrop_ff <= lostSel_ff; // [RQ1] [RQ2] [RQ3]
               active_ff <= active_ff & ~lostSel_ff;
               txEqOk_ff <= txEqOk_ff & ~lostSel_ff;
               if (!ctrl_ff[`CLR_CTRL_RECOVER] ||
                   (active_ff & ~lostSel_ff) == {NCH{1'b0}}) begin
                  chanDrop_ff <= active_ff | lostSel_ff; // [RQ10]
                  active_ff <= {NCH{1'b0}};
                  txEqOk_ff <= {NCH{1'b0}};
                  callDrop_ff <= 1'b1; // [RQ10]
                  state_ff <= `CLR_ST_IDLE;
               end else begin
                  state_ff <= `CLR_ST_IND; // [RQ2]
               end
            end
            `CLR_ST_IND: begin
               if (eqLostFlag_ff) begin
                  txEqOk_ff <= {NCH{1'b0}}; // [RQ4]
               end
               state_ff <= `CLR_ST_RESEQ; // [RQ14]
            end
            `CLR_ST_RESEQ: begin
               chanIds_ff <= seqIds; // [RQ5]
               if (lostSel_ff != {NCH{1'b0}}) begin
                  if (rateMult_ff != 8'h00) begin
                     rateMult_ff <= rateMult_ff - 8'h01; // [RQ8] [RQ7]
                  end
                  subRateMult_ff <= 8'h00; // [RQ8]
                  reEqStart_ff <= 1'b1; // [RQ6] [RQ14]
                  state_ff <= `CLR_ST_REEQ;
               end else begin
                  state_ff <= `CLR_ST_IDLE;
               end
            end
            `CLR_ST_REEQ: begin
               // Data stays unaligned until the equalizer reports done.
               if (eqDone) begin
                  txEqOk_ff <= active_ff; // [RQ6]
                  // A loss reported in this same cycle keeps the flag set.
                  eqLostFlag_ff <= eqLostDetect && callActive;
                  addChanReq_ff <= ctrl_ff[`CLR_CTRL_RESTORE] &
                                   (lostSel_ff != {NCH{1'b0}}); // [RQ9]
                  lostSel_ff <= {NCH{1'b0}};
                  state_ff <= `CLR_ST_IDLE;
               end
            end
            default: state_ff <= `CLR_ST_IDLE;
         endcase
      end
   end
endmodule

// [verification/clr_peer_model.sv]
// Peer endpoint and equalizer stand-in facing the recovery controller.
`timescale 1ns/1ns
module clr_peer_model (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic [7:0] chanDrop,
   input wire logic reEqStart,
   input wire logic peerLose,
   input wire logic slowEq,
   output logic [7:0] rxEqOk,
   output logic eqDone
);
   logic [7:0] alive_ff;
   logic [4:0] wait_ff;
   // A dropped channel carries no indicator, so it reads as 0.
   assign rxEqOk = peerLose ? 8'h00 : alive_ff;
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         alive_ff <= 8'hFF;
         wait_ff <= 5'h00;
         eqDone <= 1'h0;
      end else begin
         alive_ff <= alive_ff & ~chanDrop;
         eqDone <= (wait_ff == 5'h01);
         if (reEqStart) begin
            wait_ff <= slowEq ? 5'h14 : 5'h01;
         end else if (wait_ff != 5'h00) begin
            wait_ff <= wait_ff - 5'h01;
         end
      end
   end
endmodule

// [verification/clr_top_assertions.sv]
// Concurrent checks on the recovery controller ports.
`timescale 1ns/1ns
`include "clr_consts.vh"
module clr_top_assertions (
   input wire clock,
   input wire arst_n,
   input wire [`CLR_NCH-1:0] alignLost,
   input wire [`CLR_NCH-1:0] chanDrop_ff,
   input wire [`CLR_NCH-1:0] txEqOk_ff,
   input wire [`CLR_NCH-1:0] txAlarmOk,
   input wire [`CLR_NCH-1:0] syncRestart,
   input wire [`CLR_NCH*`CLR_IDW-1:0] chanIds_ff,
   input wire [7:0] rateMult_ff,
   input wire [7:0] subRateMult_ff,
   input wire reEqStart_ff,
   input wire callDrop_ff,
   input wire peerEqLost_ff,
   input wire recovering_ff
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);
   wire stepDone = reEqStart_ff && recovering_ff;
   wire partDrop = (|chanDrop_ff) && !(&chanDrop_ff) && !callDrop_ff;
   AST_RATE_STEP: assert property (
      stepDone |-> rateMult_ff == ($past(rateMult_ff) == 8'h00 ?
      8'h00 : $past(rateMult_ff) - 8'h01)) else $error("rate not stepped");
   AST_SUB_ZERO: assert property (
      stepDone |-> subRateMult_ff == 8'h00) else $error("sub rate kept");
   AST_DROP_TO_REEQ: assert property (
      partDrop && recovering_ff |-> !reEqStart_ff ##1 !reEqStart_ff
      ##1 reEqStart_ff) else $error("re-equalize not two after drop");
   AST_IDS_WITH_REEQ: assert property (
      $past(recovering_ff) && $changed(chanIds_ff) |-> reEqStart_ff)
      else $error("ids changed apart from re-equalize start");
   AST_IND_BEFORE_REEQ: assert property (
      recovering_ff && !reEqStart_ff && !(|chanDrop_ff) &&
      |($past(txEqOk_ff) & ~txEqOk_ff) |-> ##1 reEqStart_ff)
      else $error("indicator drop not followed");
   AST_ALARM_LOW: assert property (
      !(|($past(alignLost, 2) & $past(alignLost) & alignLost & txAlarmOk)))
      else $error("alarm bit high while alignment lost");
   AST_SYNC_RESTART: assert property (
      |(alignLost & ~$past(alignLost)) |-> ##[0:3] (|syncRestart))
      else $error("no sync restart after alignment loss");
   AST_CALL_DROP: assert property (
      (&chanDrop_ff) |-> (callDrop_ff || $past(callDrop_ff))
      or (##1 callDrop_ff)) else $error("all dropped without call drop");
   cover property (stepDone);
   cover property (callDrop_ff);
   cover property ($rose(peerEqLost_ff));
endmodule
bind clr_top clr_top_assertions clr_top_assertions_inst (.clock, .arst_n,
   .alignLost, .chanDrop_ff, .txEqOk_ff, .txAlarmOk, .syncRestart,
   .chanIds_ff, .rateMult_ff, .subRateMult_ff, .reEqStart_ff,
   .callDrop_ff, .peerEqLost_ff, .recovering_ff);

// [verification/clr_top_test.sv]
// Self-checking bench for the channel loss recovery controller.
`timescale 1ns/1ns
`include "clr_consts.vh"
module clr_top_test;
   logic clock = 0, arst_n = 0, avs_read = 0, avs_write = 0;
   logic [3:0] avs_address = 0;
   logic [31:0] avs_writedata = 0, rd;
   logic [7:0] alignLost = 0, netDisc = 0;
   logic discNegotiated = 0, masterCrcErr = 0, masterFarEndErr = 0;
   logic eqLostDetect = 0, peerLose = 0, slowEq = 0;
   wire [31:0] avs_readdata;
   wire [7:0] rxEqOk, chanDrop, txEqOk, txAlarmOk, rateMult, subRate;
   wire [23:0] chanIds;
   wire avs_waitrequest, eqDone, reEqStart, callDrop, addChanReq;
   wire peerEqLost, recovering, irq;
   int bad_count = 0, n_checks = 0;
   clr_top clr_top_inst (.clock, .arst_n, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
      .alignLost, .netDisc, .discNegotiated, .masterCrcErr,
      .masterFarEndErr, .eqLostDetect, .eqDone, .rxEqOk,
      .chanDrop_ff(chanDrop), .txEqOk_ff(txEqOk), .txAlarmOk,
      .syncRestart(), .chanIds_ff(chanIds), .rateMult_ff(rateMult),
      .subRateMult_ff(subRate), .reEqStart_ff(reEqStart),
      .callDrop_ff(callDrop), .addChanReq_ff(addChanReq),
      .peerEqLost_ff(peerEqLost), .recovering_ff(recovering), .irq_ff(irq));
   clr_peer_model clr_peer_model_inst (.clock, .arst_n, .chanDrop,
      .reEqStart, .peerLose, .slowEq, .rxEqOk, .eqDone);
   initial begin
      forever #2 clock = ~clock;
   end
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic check(string what, logic [31:0] exp, logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic logic ev(int i);
      case (i)
         0: return |chanDrop;
         1: return reEqStart;
         2: return eqDone;
         3: return callDrop;
         default: return peerEqLost;
      endcase
   endfunction
   // Events are looked at on the falling edge, where registers have settled.
   task automatic waitEv(int i);
      int k;
      k = 0;
      do begin
         @(negedge clock);
         k++;
      end while (ev(i) !== 1'h1 && k < 200);
      check($sformatf("event %0d", i), 1, ev(i));
      if (ev(i) !== 1'h1) final_report();
   endtask
   task automatic avXfer(logic wr, logic [3:0] a, logic [31:0] d);
      int k;
      @(posedge clock);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !wr;
      avs_write <= wr;
      k = 0;
      do begin
         @(posedge clock);
         k++;
      end while (avs_waitrequest !== 1'h0 && k < 50);
      check("waitrequest", 0, avs_waitrequest);
      if (avs_waitrequest !== 1'h0) final_report();
      rd = avs_readdata;
      avs_read <= 1'h0;
      avs_write <= 1'h0;
   endtask
   task automatic checkIds(logic [7:0] m);
      logic [23:0] e, cm;
      int n;
      e = 0;
      cm = 0;
      n = 0;
      for (int c = 0; c < 8; c++) if (m[c]) begin
         e[c*3 +: 3] = n[2:0];
         cm[c*3 +: 3] = 3'h7;
         n++;
      end
      check("chanIds", e, chanIds & cm);
   endtask
   task automatic s_regs;
      avXfer(0, `CLR_REG_CTRL, 0);
      check("ctrl", 32'h0000_0001, rd);
      avXfer(0, `CLR_REG_FA_LIMIT, 0);
      check("faLimit", 32'h0000_0FA0, rd);
      avXfer(0, 4'hF, 0);
      check("unmapped", 32'h0000_0000, rd);
      avXfer(1, `CLR_REG_CTRL, 32'h0000_0007);
      avXfer(1, `CLR_REG_FA_LIMIT, 32'h0000_0004);
      avXfer(1, `CLR_REG_CHANS, 32'h0000_00FF);
      avXfer(1, `CLR_REG_RATE, 32'h0000_0306);
      avXfer(1, `CLR_REG_IRQ_EN, 32'h0000_000F);
      checkIds(8'hFF);
   endtask
   task automatic s_align;
      @(posedge clock);
      alignLost <= 8'h04;
      waitEv(0);
      check("chanDrop", 8'h04, chanDrop);
      check("alarm", 0, txAlarmOk[2]);
      waitEv(1);
      check("rate", 8'h05, rateMult);
      check("subRate", 8'h00, subRate);
      checkIds(8'hFB);
      @(posedge clock);
      alignLost <= 8'h00;
      waitEv(2);
      @(negedge clock);
      check("txEqOk", 8'hFB, txEqOk);
      check("addChanReq", 1, addChanReq);
      avXfer(0, `CLR_REG_STATUS, 0);
      check("status rate", 16'h0005, rd[23:8]);
      avXfer(0, `CLR_REG_IRQ_STAT, 0);
      check("irqStat", 32'h0000_0003, rd);
      check("irq", 1, irq);
      avXfer(1, `CLR_REG_IRQ_CLR, 32'h0000_000F);
      repeat (2) @(negedge clock);
      check("irq cleared", 0, irq);
   endtask
   task automatic s_master;
      @(posedge clock);
      netDisc <= 8'h02;
      slowEq <= 1'h1;
      @(posedge clock);
      netDisc <= 8'h01;
      discNegotiated <= 1'h1;
      @(posedge clock);
      netDisc <= 8'h00;
      repeat (8) @(negedge clock);
      check("refused", 0, recovering);
      @(posedge clock);
      netDisc <= 8'h01;
      discNegotiated <= 1'h0;
      @(posedge clock);
      netDisc <= 8'h00;
      waitEv(0);
      check("chanDrop", 8'h01, chanDrop);
      waitEv(1);
      check("rate", 8'h04, rateMult);
      checkIds(8'hFA);
      waitEv(2);
   endtask
   task automatic s_err;
      avXfer(1, `CLR_REG_ERR_LIMIT, 32'h0000_0002);
      @(posedge clock);
      masterCrcErr <= 1'h1;
      @(posedge clock);
      masterCrcErr <= 1'h0;
      masterFarEndErr <= 1'h1;
      eqLostDetect <= 1'h1;
      @(posedge clock);
      masterFarEndErr <= 1'h0;
      eqLostDetect <= 1'h0;
      waitEv(0);
      check("chanDrop", 8'h02, chanDrop);
      waitEv(1);
      check("rate", 8'h03, rateMult);
      check("txEqOk ind", 8'h00, txEqOk);
      waitEv(2);
   endtask
   task automatic s_peer;
      @(posedge clock);
      peerLose <= 1'h1;
      waitEv(4);
      avXfer(0, `CLR_REG_STATUS, 0);
      check("status peer", 1, rd[4]);
      peerLose <= 1'h0;
   endtask
   task automatic s_local;
      @(posedge clock);
      eqLostDetect <= 1'h1;
      @(posedge clock);
      eqLostDetect <= 1'h0;
      waitEv(1);
      check("txEqOk low", 8'h00, txEqOk);
      waitEv(2);
      @(negedge clock);
      check("txEqOk back", 8'hF8, txEqOk);
   endtask
   task automatic s_drop;
      avXfer(1, `CLR_REG_CTRL, 32'h0000_0004);
      avXfer(1, `CLR_REG_CHANS, 32'h0000_00FF);
      @(posedge clock);
      alignLost <= 8'h80;
      waitEv(3);
      check("chanDrop all", 8'hFF, chanDrop);
      avXfer(0, `CLR_REG_CTRL, 0);
      check("ctrl active", 32'h0000_0000, rd);
      avXfer(0, `CLR_REG_IRQ_STAT, 0);
      check("irq drop", 1, rd[2]);
   endtask
   initial begin
      repeat (12) @(posedge clock);
      arst_n <= 1'h1;
      s_regs();
      s_align();
      s_master();
      s_err();
      s_peer();
      s_local();
      s_drop();
      final_report();
   end
endmodule
